// ==== logic/rtcw_pkg.sv ====
// package: register map, field layouts and timing of the rtc register block
package rtcw_pkg;
    // register byte addresses
    localparam logic [14:0] OFF_FLAGS = 15'h7FF0;
    localparam logic [14:0] OFF_CENT = 15'h7FF1;
    localparam logic [14:0] OFF_ASEC = 15'h7FF2;
    localparam logic [14:0] OFF_AMIN = 15'h7FF3;
    localparam logic [14:0] OFF_AHR = 15'h7FF4;
    localparam logic [14:0] OFF_ADATE = 15'h7FF5;
    localparam logic [14:0] OFF_ICFG = 15'h7FF6;
    localparam logic [14:0] OFF_WDOG = 15'h7FF7;
    localparam logic [14:0] OFF_CAL = 15'h7FF8;
    localparam logic [14:0] OFF_SEC = 15'h7FF9;
    localparam logic [14:0] OFF_MIN = 15'h7FFA;
    localparam logic [14:0] OFF_HR = 15'h7FFB;
    localparam logic [14:0] OFF_WDAY = 15'h7FFC;
    localparam logic [14:0] OFF_DATE = 15'h7FFD;
    localparam logic [14:0] OFF_MON = 15'h7FFE;
    localparam logic [14:0] OFF_YEAR = 15'h7FFF;
    localparam logic [10:0] RTC_PAGE = 11'h7FF;
    // time fields: sec, min, hour, weekday, date, month, year, century
    localparam logic [7:0] TK_MASK [8] = '{8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF, 8'hFF};
    localparam logic [7:0] TK_TOP [8] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h99};
    localparam logic [7:0] TK_BOT [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    localparam logic [7:0] ALM_MASK [4] = '{8'hFF, 8'hFF, 8'hBF, 8'hBF};
    localparam logic [7:0] ICFG_MASK = 8'hEC;
    localparam logic [7:0] CAL_MASK = 8'hBF;
    localparam logic [7:0] ICFG_RST = 8'h00;
    localparam logic [7:0] CAL_RST = 8'h00;
    // flags bit positions
    localparam int FL_WDF = 7;
    localparam int FL_AF = 6;
    localparam int FL_PF = 5;
    localparam int FL_OSC_FAILED_FLAG = 4;
    localparam int FL_CAL = 2;
    localparam int FL_W = 1;
    localparam int FL_R = 0;
    // oscillator divider and calibration
    localparam logic [15:0] SEC_TICKS = 16'h8000;
    localparam logic [15:0] CAL_SHORT = 16'h0080;
    localparam logic [15:0] CAL_LONG = 16'h0100;
    localparam int SQ_BIT = 5;
    // interrupt pulse length
    localparam int CLK_HZ = 100_000_000;
    localparam int PULSE_MS = 200;
    localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic timeout_irq_enable;
        logic match_irq_enable;
        logic supply_loss_irq_enable;
        logic rsv4;
        logic active_high;
        logic pulse_mode;
        logic [1:0] rsv;
    } rtcw_icfg_type;

    typedef struct packed {
        logic osc_disable_bit;
        logic rsv6;
        logic trim_sign;
        logic [4:0] trim_mag;
    } rtcw_cal_type;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [14:0] addr;
        logic [7:0] dq;
    } rtcw_bus_type;

    // last date of a month, bcd, with leap years
    function automatic logic [7:0] rtcw_month_end(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8))
            || (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
        case (mon)
            8'h02: rtcw_month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: rtcw_month_end = 8'h30;
            default: rtcw_month_end = 8'h31;
        endcase
    endfunction : rtcw_month_end
endpackage : rtcw_pkg

// ==== logic/rtcw_regs.sv ====
// rtc register block: timekeeping, alarm, watchdog, calibration, flags, interrupt pin
// Behaviour
// - watchdog timeout sets its flag; drives interrupt only when its enable is 1
// - alarm match sets its flag; drives interrupt only when its enable is 1
// - supply loss sets its flag; drives interrupt only when its enable is 1
// - polarity 1: active high push-pull, driven only while supply is good
// - polarity 0: active low open-drain, kept even without supply
// - pulse mode asserts about 200 ms; flags read ends it early
// - level mode holds active until the flags register is read
// - interrupt config starts 00h and survives supply loss
// - reading flags clears timeout, match and supply-loss flags
// - at power up flags load 00h except oscillator-failed bit
// - time registers are packed bcd with documented ranges
// - oscillator disable bit stops oscillator at 1, runs at 0; default 0
// - calibration register starts 00h and survives supply loss
// - write protect 1 blocks timeout bits; clear it in an earlier write
// - watchdog interval is six-bit value times 31.25 ms tick
// - timeout value zero disables the watchdog
// - supply-loss flag sets below threshold; clears on flags read or power up
// - alarm mask bit 0 compares field, 1 ignores it
// - write-time bit freezes visible time and opens register writes
// - clearing write-time blocks writes and loads changed time as base
// - reserved bits read zero and ignore writes
// - strobe write reloads watchdog counter; strobe reads zero
// - watchdog counts down on 32 Hz tick; zero sets flag
// - calibration-output bit toggles interrupt at 512 Hz, untrimmed
// - trim magnitude low five bits, sign bit 1 speeds clock up
`timescale 1ns/1ns
module rtcw_regs #(
    parameter int PULSE_CYCLES = rtcw_pkg::PULSE_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // parallel register bus
    input wire rtcw_pkg::rtcw_bus_type bus_i,
    output logic [7:0] dq_o,
    output logic dq_oe_n_o,
    // oscillator and supply monitor
    input wire logic tick32k_i,
    input wire logic osc_fail_i,
    input wire logic supply_ok_i,
    // interrupt pin
    output logic int_o,
    output logic int_oe_n_o
);
    import rtcw_pkg::*;

    localparam int PW = $clog2(PULSE_CYCLES + 1);

    logic [7:0] tk [8];
    logic [7:0] next_tk [8];
    logic [7:0] vis [8];
    logic [7:0] alm [4];
    rtcw_icfg_type icfg;
    rtcw_cal_type cal;
    logic [5:0] timeout_interval;
    logic timeout_write_protect;
    logic [5:0] wd_cnt;
    logic timeout_flag;
    logic match_flag;
    logic supply_loss_flag;
    logic osc_failed_flag;
    logic cal_out;
    logic wr_time;
    logic rd_freeze;
    logic dirty;
    logic [15:0] pre;
    logic [9:0] div;
    logic [5:0] cal_min;
    logic alm_chk;
    logic sup_q;
    logic wr_q;
    logic rd_q;
    logic int_act;
    logic [PW-1:0] pcnt;
    logic [7:0] rdata;
    logic [7:0] c;

    // bus decode
    wire sel = supply_ok_i && !bus_i.ce_n && bus_i.addr[14:4] == RTC_PAGE;
    wire wr_lvl = sel && !bus_i.we_n;
    wire rd_lvl = sel && bus_i.we_n && !bus_i.oe_n;
    wire wr_go = wr_lvl && !wr_q;
    wire rd_go = rd_lvl && !rd_q;
    wire [7:0] wd = bus_i.dq;
    wire [3:0] ix = bus_i.addr[3:0];
    wire flags_rd = rd_go && bus_i.addr == OFF_FLAGS;
    wire wr_flags = wr_go && bus_i.addr == OFF_FLAGS;
    wire wr_wdog = wr_go && bus_i.addr == OFF_WDOG;
    wire wr_open = wr_go && wr_time;
    wire wr_icfg = wr_open && bus_i.addr == OFF_ICFG;
    wire wr_cal = wr_open && bus_i.addr == OFF_CAL;
    wire wr_alm = wr_open && ix >= 4'h2 && ix <= 4'h5;
    wire wr_vis = wr_open && (ix == 4'h1 || ix >= 4'h9);
    wire [2:0] vix = (ix == 4'h1) ? 3'h7 : 3'(ix - 4'h9);
    wire [1:0] aix = 2'(ix - 4'h2);

    // oscillator gating and dividers
    wire osc_run = tick32k_i && !cal.osc_disable_bit;
    wire wd_tick = osc_run && div == 10'h3FF;
    wire sq512 = div[SQ_BIT];
    wire trim_on = cal.trim_mag != 5'h00 && cal_min < {cal.trim_mag, 1'b0} && tk[0] == 8'h00;
    wire [15:0] sec_len = !trim_on ? SEC_TICKS
        : cal.trim_sign ? SEC_TICKS - CAL_SHORT : SEC_TICKS + CAL_LONG;
    wire sec_step = osc_run && pre >= sec_len - 16'h0001;
    wire [7:0] date_top = rtcw_month_end(tk[5], tk[6]);
    wire frozen = wr_time || rd_freeze;
    wire base_load = wr_flags && wr_time && !wd[FL_W] && dirty;

    // events
    wire wd_evt = wd_tick && timeout_interval != 6'h00 && wd_cnt <= 6'h01 && !(wr_wdog && wd[7]);
    wire al_evt = alm_chk && (alm[0][7] || alm[0][6:0] == tk[0][6:0])
        && (alm[1][7] || alm[1][6:0] == tk[1][6:0])
        && (alm[2][7] || alm[2][6:0] == tk[2][6:0])
        && (alm[3][7] || alm[3][6:0] == tk[4][6:0]);
    wire pf_evt = sup_q && !supply_ok_i;
    wire pw_up = !sup_q && supply_ok_i;
    wire int_evt = (wd_evt && icfg.timeout_irq_enable)
        || (al_evt && icfg.match_irq_enable)
        || (pf_evt && icfg.supply_loss_irq_enable);
    wire pin_act = cal_out ? sq512 : int_act;
    wire next_int = icfg.active_high ? pin_act : 1'b0;
    wire next_oe_n = icfg.active_high ? !supply_ok_i : !pin_act;

    // bcd carry chain for the time counters
    always_comb begin
        c = 8'h00;
        c[0] = tk[0] == TK_TOP[0];
        c[1] = c[0] && tk[1] == TK_TOP[1];
        c[2] = c[1] && tk[2] == TK_TOP[2];
        c[4] = c[2] && tk[4] == date_top;
        c[5] = c[4] && tk[5] == TK_TOP[5];
        c[6] = c[5] && tk[6] == TK_TOP[6];
    end

    // next time, each field wraps from top to bottom
    always_comb begin
        logic cin;
        logic [7:0] top;
        cin = 1'b0;
        top = 8'h00;
        for (int i = 0; i < 8; i++) begin
            case (i)
                0: cin = sec_step;
                3: cin = sec_step && c[2];
                4: cin = sec_step && c[2];
                default: cin = sec_step && c[i-1];
            endcase
            top = (i == 4) ? date_top : TK_TOP[i];
            if (base_load) begin
                next_tk[i] = vis[i];
            end else if (cin && tk[i] >= top) begin
                next_tk[i] = TK_BOT[i];
            end else if (cin && tk[i][3:0] >= 4'h9) begin
                next_tk[i] = {tk[i][7:4] + 4'h1, 4'h0};
            end else if (cin) begin
                next_tk[i] = {tk[i][7:4], tk[i][3:0] + 4'h1};
            end else begin
                next_tk[i] = tk[i];
            end
        end
    end

    // read data with reserved bits at zero
    always_comb begin
        case (ix)
            4'h0: rdata = {timeout_flag, match_flag, supply_loss_flag, osc_failed_flag, 1'b0, cal_out,
                wr_time, rd_freeze};
            4'h2, 4'h3, 4'h4, 4'h5: rdata = alm[aix];
            4'h6: rdata = icfg & ICFG_MASK;
            4'h7: rdata = {1'b0, timeout_write_protect, timeout_interval};
            4'h8: rdata = cal & CAL_MASK;
            default: rdata = vis[vix];
        endcase
    end

    // bus strobes and read port
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            dq_o <= 8'h00;
            dq_oe_n_o <= 1'b1;
        end else begin
            wr_q <= wr_lvl;
            rd_q <= rd_lvl;
            dq_o <= rdata;
            dq_oe_n_o <= !rd_lvl;
        end
    end

    // timekeeping counters, dividers and calibration minute
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tk <= TK_BOT;
            pre <= 16'h0000;
            div <= 10'h000;
            cal_min <= 6'h00;
            alm_chk <= 1'b0;
            sup_q <= 1'b0;
        end else begin
            tk <= next_tk;
            if (sec_step) begin
                pre <= 16'h0000;
            end else if (osc_run) begin
                pre <= pre + 16'h0001;
            end
            if (osc_run) begin
                div <= div + 10'h001;
            end
            if (sec_step && c[0]) begin
                cal_min <= cal_min + 6'h01;
            end
            alm_chk <= sec_step;
            sup_q <= supply_ok_i;
        end
    end

    // visible time: tracks counters unless frozen, written when open
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            vis <= TK_BOT;
            dirty <= 1'b0;
        end else begin
            if (wr_vis) begin
                vis[vix] <= wd & TK_MASK[vix];
            end else if (!frozen) begin
                vis <= next_tk;
            end
            if (wr_vis) begin
                dirty <= 1'b1;
            end else if (!wr_time) begin
                dirty <= 1'b0;
            end
        end
    end

    // alarm, interrupt config and calibration registers
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            alm <= '{default: 8'h00};
            icfg <= ICFG_RST;
            cal <= CAL_RST;
        end else begin
            if (wr_alm) begin
                alm[aix] <= wd & ALM_MASK[aix];
            end
            if (wr_icfg) begin
                icfg <= wd & ICFG_MASK;
            end
            if (wr_cal) begin
                cal <= wd & CAL_MASK;
            end
        end
    end

    // watchdog load register and down counter
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timeout_interval <= 6'h00;
            timeout_write_protect <= 1'b0;
            wd_cnt <= 6'h00;
        end else begin
            if (wr_wdog) begin
                timeout_write_protect <= wd[6];
                if (!timeout_write_protect) begin
                    timeout_interval <= wd[5:0];
                end
            end
            if (wr_wdog && wd[7]) begin
                wd_cnt <= timeout_interval;
            end else if (wd_tick && timeout_interval != 6'h00) begin
                wd_cnt <= (wd_cnt <= 6'h01) ? timeout_interval : wd_cnt - 6'h01;
            end
        end
    end

    // flags: events set, read clears, set wins over clear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timeout_flag <= 1'b0;
            match_flag <= 1'b0;
            supply_loss_flag <= 1'b0;
            osc_failed_flag <= 1'b0;
            cal_out <= 1'b0;
            wr_time <= 1'b0;
            rd_freeze <= 1'b0;
        end else if (pw_up) begin
            timeout_flag <= 1'b0;
            match_flag <= 1'b0;
            supply_loss_flag <= 1'b0;
            osc_failed_flag <= osc_failed_flag || osc_fail_i;
            cal_out <= 1'b0;
            wr_time <= 1'b0;
            rd_freeze <= 1'b0;
        end else begin
            timeout_flag <= wd_evt || (timeout_flag && !flags_rd);
            match_flag <= al_evt || (match_flag && !flags_rd);
            supply_loss_flag <= pf_evt || (supply_loss_flag && !flags_rd);
            if (osc_fail_i) begin
                osc_failed_flag <= 1'b1;
            end else if (wr_flags && wr_time) begin
                osc_failed_flag <= wd[FL_OSC_FAILED_FLAG];
            end
            if (wr_flags && wr_time) begin
                cal_out <= wd[FL_CAL];
            end
            if (wr_flags) begin
                wr_time <= wd[FL_W];
                rd_freeze <= wd[FL_R];
            end
        end
    end

    // interrupt state, pulse timer and pin
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_act <= 1'b0;
            pcnt <= '0;
            int_o <= 1'b0;
            int_oe_n_o <= 1'b1;
        end else begin
            if (int_evt) begin
                int_act <= 1'b1;
                pcnt <= PW'(PULSE_CYCLES);
            end else if (flags_rd) begin
                int_act <= 1'b0;
            end else if (icfg.pulse_mode && int_act) begin
                pcnt <= pcnt - PW'(1);
                if (pcnt <= PW'(1)) begin
                    int_act <= 1'b0;
                end
            end
            int_o <= next_int;
            int_oe_n_o <= next_oe_n;
        end
    end

    a_wd_flag_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wd_evt && !pw_up |=> timeout_flag) else $error("timeout did not set flag");
    a_match_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        al_evt && !pw_up |=> match_flag) else $error("alarm match did not set flag");
    a_flags_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        flags_rd && !wd_evt && !al_evt && !pf_evt |=> !timeout_flag && !match_flag && !supply_loss_flag)
        else $error("flags read did not clear");
    a_od_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !icfg.active_high && !cal_out && int_act |=> !int_o && !int_oe_n_o) else $error("open drain not low");
    a_pp_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        icfg.active_high && !cal_out && supply_ok_i && int_act |=> int_o && !int_oe_n_o)
        else $error("push pull not high");
    a_level_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        int_act && !icfg.pulse_mode && !flags_rd |=> int_act) else $error("level dropped before read");
    a_wd_protect: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_wdog && timeout_write_protect |=> $stable(timeout_interval)) else $error("protected interval changed");
    a_wdt_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        timeout_interval == 6'h00 && !timeout_flag |=> !timeout_flag) else $error("watchdog fired while disabled");
    a_pf_flag_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pf_evt |=> supply_loss_flag) else $error("supply loss did not set flag");
    a_freeze_vis: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        frozen && !wr_vis |=> $stable(vis[0])) else $error("frozen seconds changed");
    a_pulse_end: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        int_act && icfg.pulse_mode && pcnt == PW'(1) && !int_evt && !flags_rd |=> !int_act)
        else $error("pulse did not end");
endmodule : rtcw_regs

// ==== dv/rtcw_host.sv ====
// host processor model on the parallel register bus
`timescale 1ns/1ns
module rtcw_host (
    // clock
    input wire logic mclk_i,
    // bus towards the block
    output rtcw_pkg::rtcw_bus_type bus_o,
    input wire logic [7:0] dq_i,
    input wire logic dq_oe_n_i
);
    import rtcw_pkg::*;

    // idle bus, deselected
    initial begin
        bus_o = '{1'b1, 1'b1, 1'b1, 15'h0000, 8'h00};
    end

    // one write per select phase, then a released idle cycle
    // callers open writes with the write-time bit first
    // watchdog interval changes follow a write that clears protect
    // strobe is a plain write of bit 7
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        bus_o = '{1'b0, 1'b0, 1'b1, a, d};
        @(posedge mclk_i);
        #1;
        // released data lines show a changed value, not the last one
        bus_o = '{1'b1, 1'b1, 1'b1, a, ~d};
        @(posedge mclk_i);
    endtask : wr

    // read held until the block drives the data lines
    task automatic rd(input logic [14:0] a, output logic [7:0] d);
        int k;
        @(posedge mclk_i);
        #1;
        bus_o = '{1'b0, 1'b1, 1'b0, a, ~bus_o.dq};
        k = 0;
        do begin
            @(posedge mclk_i);
            k = k + 1;
        end while (dq_oe_n_i !== 1'b0 && k < 8);
        d = (dq_oe_n_i === 1'b0) ? dq_i : 8'hXX;
        #1;
        bus_o = '{1'b1, 1'b1, 1'b1, a, ~bus_o.dq};
    endtask : rd
endmodule : rtcw_host

// ==== dv/rtcw_regs_tb.sv ====
// self-checking bench for the rtc register block
`timescale 1ns/1ns
module rtcw_regs_tb;
    import rtcw_pkg::*;
    localparam logic [14:0] TADR [7] = '{OFF_SEC, OFF_MIN, OFF_HR, OFF_WDAY, OFF_DATE, OFF_MON, OFF_YEAR};
    localparam logic [7:0] TSET [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
    localparam logic [7:0] TNEW [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic tick32k_i = 1'b0;
    logic osc_fail_i = 1'b0;
    logic supply_ok_i = 1'b1;
    rtcw_bus_type bus;
    logic [7:0] dq_o;
    logic dq_oe_n_o;
    logic int_o;
    logic int_oe_n_o;
    logic [7:0] rv;
    logic last;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    // clock, and oscillator ticks every other cycle to keep seconds short
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) tick32k_i <= #1 ~tick32k_i;

    // hang guard
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    rtcw_regs #(.PULSE_CYCLES(50)) rtcw_regs_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
        .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .tick32k_i(tick32k_i), .osc_fail_i(osc_fail_i),
        .supply_ok_i(supply_ok_i), .int_o(int_o), .int_oe_n_o(int_oe_n_o));

    rtcw_host rtcw_host_i (.mclk_i(mclk_i), .bus_o(bus), .dq_i(dq_o), .dq_oe_n_i(dq_oe_n_o));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
        rtcw_host_i.rd(a, rv);
        chk(rv, exp, $sformatf("read of %h", a));
    endtask : rchk

    // wait for a pin state, bounded, then compare it
    task automatic wait_pin(input logic want_int, input logic want_oe_n, input int limit);
        n = 0;
        while ({int_o, int_oe_n_o} !== {want_int, want_oe_n} && n < limit) begin
            @(negedge mclk_i);
            n = n + 1;
        end
        chk({6'h00, int_o, int_oe_n_o}, {6'h00, want_int, want_oe_n}, "interrupt pin");
    endtask : wait_pin

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (4) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        // reset values and refused writes
        rchk(OFF_ICFG, 8'h00);
        rchk(OFF_CAL, 8'h00);
        rchk(OFF_FLAGS, 8'h00);
        rtcw_host_i.wr(OFF_ICFG, 8'hFF);
        rchk(OFF_ICFG, 8'h00);
        rtcw_host_i.wr(OFF_FLAGS, 8'h02);
        rtcw_host_i.wr(OFF_ICFG, 8'hFF);
        rchk(OFF_ICFG, 8'hEC);
        rtcw_host_i.wr(OFF_CAL, 8'h40);
        rchk(OFF_CAL, 8'h00);
        // alarm on second zero only, time one second before the year wraps
        rtcw_host_i.wr(OFF_ASEC, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rtcw_host_i.wr(15'(OFF_AMIN + i), 8'h80);
        end
        rtcw_host_i.wr(OFF_ICFG, 8'h48);
        for (int i = 0; i < 7; i++) begin
            rtcw_host_i.wr(TADR[i], TSET[i]);
        end
        rtcw_host_i.wr(OFF_FLAGS, 8'h00);
        rtcw_host_i.wr(OFF_ICFG, 8'hFF);
        rchk(OFF_ICFG, 8'h48);
        wait_pin(1'b1, 1'b0, 70000);
        rchk(OFF_FLAGS, 8'h40);
        repeat (3) @(negedge mclk_i);
        chk({6'h00, int_o, int_oe_n_o}, 8'h00, "level release");
        rchk(OFF_FLAGS, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rchk(TADR[i], TNEW[i]);
        end
        // watchdog time-out as an open-drain pulse
        rtcw_host_i.wr(OFF_FLAGS, 8'h02);
        rtcw_host_i.wr(OFF_ICFG, 8'h84);
        rtcw_host_i.wr(OFF_FLAGS, 8'h00);
        rtcw_host_i.wr(OFF_WDOG, 8'h01);
        rtcw_host_i.wr(OFF_WDOG, 8'h41);
        rtcw_host_i.wr(OFF_WDOG, 8'hC1);
        wait_pin(1'b0, 1'b0, 4200);
        repeat (40) @(negedge mclk_i);
        chk({7'h00, int_oe_n_o}, 8'h00, "pulse held");
        repeat (15) @(negedge mclk_i);
        chk({7'h00, int_oe_n_o}, 8'h01, "pulse ended");
        rchk(OFF_FLAGS, 8'h80);
        rtcw_host_i.wr(OFF_WDOG, 8'h7F);
        rchk(OFF_WDOG, 8'h41);
        rtcw_host_i.wr(OFF_WDOG, 8'h00);
        rtcw_host_i.wr(OFF_WDOG, 8'h00);
        rchk(OFF_WDOG, 8'h00);
        rtcw_host_i.rd(OFF_FLAGS, rv);
        repeat (5000) @(negedge mclk_i);
        rchk(OFF_FLAGS, 8'h00);
        // supply loss, open-drain level output, oscillator failure kept
        rtcw_host_i.wr(OFF_FLAGS, 8'h02);
        rtcw_host_i.wr(OFF_ICFG, 8'h20);
        rtcw_host_i.wr(OFF_FLAGS, 8'h00);
        @(posedge mclk_i);
        #1;
        osc_fail_i = 1'b1;
        @(posedge mclk_i);
        #1;
        osc_fail_i = 1'b0;
        supply_ok_i = 1'b0;
        wait_pin(1'b0, 1'b0, 4);
        repeat (20) @(negedge mclk_i);
        chk({7'h00, int_oe_n_o}, 8'h00, "kept without supply");
        @(posedge mclk_i);
        #1;
        supply_ok_i = 1'b1;
        rchk(OFF_FLAGS, 8'h10);
        repeat (3) @(negedge mclk_i);
        chk({7'h00, int_oe_n_o}, 8'h01, "released by flags read");
        rchk(OFF_ICFG, 8'h20);
        // square wave on the pin, 64 cycles a half period here
        rtcw_host_i.wr(OFF_FLAGS, 8'h02);
        rtcw_host_i.wr(OFF_ICFG, 8'h08);
        rtcw_host_i.wr(OFF_FLAGS, 8'h06);
        n = 0;
        last = int_o;
        repeat (384) begin
            @(negedge mclk_i);
            if (int_o !== last) n = n + 1;
            last = int_o;
        end
        chk({7'h00, n >= 5 && n <= 7}, 8'h01, "square wave edges");
        // stopped oscillator freezes the divider, so the pin stops toggling
        rtcw_host_i.wr(OFF_CAL, 8'h80);
        rchk(OFF_CAL, 8'h80);
        n = 0;
        last = int_o;
        repeat (384) begin
            @(negedge mclk_i);
            if (int_o !== last) n = n + 1;
            last = int_o;
        end
        chk(8'(n), 8'h00, "stopped oscillator edges");
        give_verdict();
    end
endmodule : rtcw_regs_tb
